// [reply_capture.sv]
// holds the captured reply index and reply words
// assumes capture is a one-cycle pulse from the command sequencer
`timescale 1ns/1ps
`default_nettype none
module reply_capture #(
    parameter int WORDS = sd_cmd_pkg::REPLY_WORDS
) (
    input  wire logic                               clock,
    input  wire logic                               resetn,
    input  wire logic                               ce,
    input  wire logic                               capture,
    input  wire logic [sd_cmd_pkg::KIND_W-1:0]      kind,
    input  wire sd_cmd_pkg::reply_t                 reply,
    output logic      [sd_cmd_pkg::INDEX_W-1:0]     indexOut,
    output logic      [WORDS*sd_cmd_pkg::WORD_W-1:0] wordsOut
);

    localparam int WW = sd_cmd_pkg::WORD_W;

    generate
        if (WORDS != sd_cmd_pkg::REPLY_WORDS) begin : g_bad
            $error("reply_capture: WORDS must equal the reply word count");
        end
    endgenerate

    // long and r3 replies carry no index in the token
    wire noIndex = (kind == sd_cmd_pkg::KIND_R2) || (kind == sd_cmd_pkg::KIND_R3_R4);
    wire [sd_cmd_pkg::INDEX_W-1:0] nxt_index = noIndex ? sd_cmd_pkg::INDEX_ALL_ONES : reply.index; // RULE8

    logic [sd_cmd_pkg::INDEX_W-1:0] index_ff;

    always_ff @(posedge clock) begin
        if (!resetn) begin
            index_ff <= sd_cmd_pkg::INDEX_ALL_ONES & '0;
        end else if (ce && capture) begin
            index_ff <= nxt_index; // RULE7
        end
    end
    assign indexOut = index_ff;

    // word k takes payload bits 39+32k downto 8+32k; the top word keeps 24 bits
    genvar k;
    generate
        for (k = 0; k < WORDS; k++) begin : g_word
            localparam int LO = sd_cmd_pkg::PAYLOAD_LSB + k * WW;
            localparam int VW = (k == WORDS - 1) ? sd_cmd_pkg::LAST_WORD_W : WW;
            logic [WW-1:0] word_ff;
            wire  [WW-1:0] nxt_word = WW'(reply.payload[LO +: VW]); // RULE9 RULE10 RULE11
            always_ff @(posedge clock) begin
                if (!resetn) begin
                    word_ff <= sd_cmd_pkg::REG_RESET;
                end else if (ce && capture) begin
                    word_ff <= nxt_word;
                end
            end
            assign wordsOut[k*WW +: WW] = word_ff;
        end
    endgenerate

endmodule : reply_capture
`default_nettype wire

// [sd_card_model.sv]
// behavioural card: takes the command token and returns a reply
// reply contents and answer lag come from the bench
`timescale 1ns/1ps
`default_nettype none
module sd_card_model (
    input  wire logic                 clock,
    input  wire sd_cmd_pkg::cmd_req_t cmdReq,
    input  wire logic                 cmdValid,
    output logic                      cmdReady,
    output sd_cmd_pkg::reply_t        replyIn,
    output logic                      replyValid,
    input  wire logic [3:0]           lag,
    input  wire logic [5:0]           rIdx,
    input  wire logic [127:0]         pay
);
    initial begin
        cmdReady = 1'b0;
        replyValid = 1'b0;
        replyIn = '1;
        forever begin
            @(posedge clock);
            if (cmdValid === 1'b1) begin
                repeat (lag) @(posedge clock);
                cmdReady <= 1'b1;
                @(posedge clock);
                cmdReady <= 1'b0;
                if (cmdReq.kind != 3'h4) begin
                    repeat (lag) @(posedge clock);
                    replyIn <= {rIdx, pay};
                    replyValid <= 1'b1;
                    @(posedge clock);
                    replyValid <= 1'b0;
                    // released lines show no stale reply
                    replyIn <= ~{rIdx, pay};
                end
            end
        end
    end
endmodule : sd_card_model
`default_nettype wire

// [sd_cmd_pkg.sv]
// constants, types and register map of the card command/response block
// assumes a 32-bit apb register bus and a card-side serialiser outside this block
package sd_cmd_pkg;

    // register byte offsets
    localparam logic [7:0] OFF_ARGUMENT  = 8'h18;
    localparam logic [7:0] OFF_COMMAND   = 8'h1c;
    localparam logic [7:0] OFF_REPLY_IDX = 8'h20;
    localparam logic [7:0] OFF_REPLY_W0  = 8'h24;
    localparam logic [7:0] OFF_REPLY_W1  = 8'h28;
    localparam logic [7:0] OFF_REPLY_W2  = 8'h2c;
    localparam logic [7:0] OFF_REPLY_W3  = 8'h30;
    localparam logic [7:0] OFF_LINK_CTRL = 8'h40;

    // command register fields
    localparam int KIND_MSB  = 10;
    localparam int KIND_LSB  = 8;
    localparam int DATA_BIT  = 6;
    localparam int INDEX_MSB = 5;
    localparam int INDEX_W   = 6;
    localparam int KIND_W    = 3;

    // link control register fields
    localparam int WIDE4_BIT    = 0;
    localparam int IRQEN_BIT    = 1;
    localparam int BUSY_BIT     = 8;
    localparam int IRQSEEN_BIT  = 9;

    // reply layout: payload bit 0 is the token end bit, bits 7:0 never stored
    localparam int PAYLOAD_W   = 128;
    localparam int PAYLOAD_LSB = 8;
    localparam int WORD_W      = 32;
    localparam int REPLY_WORDS = 4;
    localparam int LAST_WORD_W = 24;

    localparam logic [31:0]        REG_RESET     = 32'h0;
    localparam logic [INDEX_W-1:0] INDEX_ALL_ONES = 6'h3f;

    typedef enum logic [2:0] {
        KIND_R1_R6 = 3'h0,
        KIND_R1B   = 3'h1,
        KIND_R2    = 3'h2,
        KIND_R3_R4 = 3'h3,
        KIND_NONE  = 3'h4
    } reply_kind_t;

    // command handed to the card-side serialiser
    typedef struct packed {
        logic [INDEX_W-1:0] index;
        logic [31:0]        argument;
        logic [KIND_W-1:0]  kind;
        logic               dataCmd;
    } cmd_req_t;

    // reply returned by the card-side deserialiser
    typedef struct packed {
        logic [INDEX_W-1:0]   index;
        logic [PAYLOAD_W-1:0] payload;
    } reply_t;

endpackage : sd_cmd_pkg

// [sd_command_response.sv]
// apb register front end and command sequencer of a memory-card host controller
// assumes an outside serialiser that sends the command token and returns the reply
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Operation
// RULE1: expected-reply field 000 R1/R6, 001 R1b, 010 R2, 011 R3/R4, 100 none.
// RULE2: data-command flag matters only for sdio interrupts in 4-bit bus mode.
// RULE3: data-command flag selects when the data line 1 interrupt is valid.
// RULE4: software sets the data-command flag for data read or write commands only.
// RULE5: six-bit command index field supplies the index sent to the card.
// RULE6: writing the command register launches it; reading returns the last written index. A write while busy is stored but not launched.
// RULE7: read-only field holds the index of the last received reply.
// RULE8: for R2 or R3 replies the reply index reads all ones.
// RULE9: R1, R1b, R6 replies put card status in word 0; other words meaningless.
// RULE10: identification or card-data queries put bits 39:8 in word 0.
// RULE11: bits 71:40, 103:72 in words 1, 2; bits 127:104 in word 3 low 24.
// RULE12: argument register goes with the command and reads back its last value.
// RULE13: with no reply expected the command ends after transmission, registers untouched.
module sd_command_response #(
    parameter int ADDR_W = 8
) (
    input  wire logic                          clock,
    input  wire logic                          resetn,
    input  wire logic                          ce,
    input  wire logic [ADDR_W-1:0]             paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    output sd_cmd_pkg::cmd_req_t               cmdReq,
    output logic                               cmdValid,
    input  wire logic                          cmdReady,
    input  wire sd_cmd_pkg::reply_t            replyIn,
    input  wire logic                          replyValid,
    input  wire logic                          dataBusy,
    input  wire logic                          card_data_line_1,
    output logic                               sdioIrq,
    output logic                               busy
);

    localparam int WW = sd_cmd_pkg::WORD_W;
    localparam int NW = sd_cmd_pkg::REPLY_WORDS;

    generate
        if (ADDR_W < 8) begin : g_bad_addr
            $error("sd_command_response: ADDR_W must be at least 8");
        end
        // the field slices below rely on the package widths and positions agreeing
        if (sd_cmd_pkg::KIND_MSB - sd_cmd_pkg::KIND_LSB + 1 != sd_cmd_pkg::KIND_W) begin : g_bad_kind
            $error("sd_command_response: reply kind field does not match its width");
        end
        if (sd_cmd_pkg::INDEX_MSB + 1 != sd_cmd_pkg::INDEX_W) begin : g_bad_index
            $error("sd_command_response: command index field does not match its width");
        end
    endgenerate

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SEND  = 3'b010,
        ST_AWAIT = 3'b100
    } seq_state_t;

    // true when the sequencer must wait for a reply after sending
    function automatic logic expectsReply(input logic [sd_cmd_pkg::KIND_W-1:0] kind);
        expectsReply = (kind != sd_cmd_pkg::KIND_NONE); // RULE1
    endfunction

    function automatic logic hitsOffset(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
        hitsOffset = (addr == ADDR_W'(off));
    endfunction

    // ---------------- apb decode ----------------
    wire setupPhase  = psel & ~penable;
    wire accessPhase = psel & penable;
    wire selArg      = hitsOffset(paddr, sd_cmd_pkg::OFF_ARGUMENT);
    wire selCmd      = hitsOffset(paddr, sd_cmd_pkg::OFF_COMMAND);
    wire selRidx     = hitsOffset(paddr, sd_cmd_pkg::OFF_REPLY_IDX);
    wire selW0       = hitsOffset(paddr, sd_cmd_pkg::OFF_REPLY_W0);
    wire selW1       = hitsOffset(paddr, sd_cmd_pkg::OFF_REPLY_W1);
    wire selW2       = hitsOffset(paddr, sd_cmd_pkg::OFF_REPLY_W2);
    wire selW3       = hitsOffset(paddr, sd_cmd_pkg::OFF_REPLY_W3);
    wire selLink     = hitsOffset(paddr, sd_cmd_pkg::OFF_LINK_CTRL);
    wire mapped      = selArg | selCmd | selRidx | selW0 | selW1 | selW2 | selW3 | selLink;

    // the bus stalls while the clock enable holds the block frozen; a read also
    // waits until its data is loaded, so a frozen setup cycle costs one wait
    // state instead of answering with the previous read's data
    logic rdLoaded_ff;
    wire  loadRead = ce & (setupPhase | accessPhase) & ~pwrite & ~rdLoaded_ff;
    assign pready  = ce & (pwrite | rdLoaded_ff);
    assign pslverr = accessPhase & ~mapped;

    wire writeTaken = accessPhase & pwrite & ce & mapped;
    wire wrArg      = writeTaken & selArg;
    wire wrCmd      = writeTaken & selCmd;
    wire wrLink     = writeTaken & selLink;

    // ---------------- registers ----------------
    logic [31:0]                      argument_ff;
    logic [sd_cmd_pkg::INDEX_W-1:0]   cmdIndex_ff;
    logic [sd_cmd_pkg::KIND_W-1:0]    cmdKind_ff;
    logic                             cmdData_ff;
    logic                             wide4_ff;
    logic                             irqEn_ff;
    logic                             irqSeen_ff;
    logic                             sdioIrq_ff;
    logic [31:0]                      prdata_ff;
    seq_state_t                       state_ff;
    seq_state_t                       nxt_state;
    sd_cmd_pkg::cmd_req_t             cmdReq_ff;

    wire [sd_cmd_pkg::INDEX_W-1:0]    replyIndex;
    wire [NW*WW-1:0]                  replyWords;

    wire [sd_cmd_pkg::INDEX_W-1:0] nxt_cmdIndex = pwdata[sd_cmd_pkg::INDEX_MSB:0]; // RULE5
    wire [sd_cmd_pkg::KIND_W-1:0]  nxt_cmdKind  = pwdata[sd_cmd_pkg::KIND_MSB:sd_cmd_pkg::KIND_LSB];
    wire                           nxt_cmdData  = pwdata[sd_cmd_pkg::DATA_BIT];

    always_ff @(posedge clock) begin
        if (!resetn) begin
            argument_ff <= sd_cmd_pkg::REG_RESET;
        end else if (wrArg) begin
            argument_ff <= pwdata; // RULE12
        end
    end

    // the field is stored on every write, even one that cannot launch
    always_ff @(posedge clock) begin
        if (!resetn) begin
            cmdIndex_ff <= '0;
            cmdKind_ff  <= '0;
            cmdData_ff  <= 1'b0;
        end else if (wrCmd) begin
            cmdIndex_ff <= nxt_cmdIndex; // RULE6
            cmdKind_ff  <= nxt_cmdKind;
            cmdData_ff  <= nxt_cmdData; // RULE4
        end
    end

    // ---------------- command sequencer ----------------
    wire isIdle   = (state_ff == ST_IDLE);
    wire isSend   = (state_ff == ST_SEND);
    wire isAwait  = (state_ff == ST_AWAIT);
    // a launch while a command is in flight is dropped to keep the token intact
    wire launch   = wrCmd & isIdle; // RULE6
    wire sent     = isSend & cmdReady;
    wire capture  = isAwait & replyValid;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (launch) begin
                    nxt_state = ST_SEND;
                end
            end
            ST_SEND: begin
                if (sent) begin
                    nxt_state = expectsReply(cmdReq_ff.kind) ? ST_AWAIT : ST_IDLE; // RULE13
                end
            end
            ST_AWAIT: begin
                if (replyValid) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            state_ff <= ST_IDLE;
        end else if (ce) begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clock) begin
        if (!resetn) begin
            cmdReq_ff <= '0;
        end else if (launch) begin
            cmdReq_ff <= '{index: nxt_cmdIndex, argument: argument_ff, kind: nxt_cmdKind,
                           dataCmd: nxt_cmdData}; // RULE5 RULE12
        end
    end

    assign cmdReq   = cmdReq_ff;
    assign cmdValid = isSend;
    assign busy     = ~isIdle;

    // reply words only change on a capture, never for a no-reply command
    reply_capture #(
        .WORDS (NW)
    ) u_reply (
        .clock    (clock),
        .resetn   (resetn),
        .ce       (ce),
        .capture  (capture), // RULE7 RULE13
        .kind     (cmdReq_ff.kind),
        .reply    (replyIn),
        .indexOut (replyIndex),
        .wordsOut (replyWords)
    );

    // ---------------- sdio interrupt window ----------------
    // in 1-bit mode line 1 carries no interrupt, so the flag is ignored there
    wire irqPath    = wide4_ff & irqEn_ff; // RULE2
    // a data command leaves line 1 to the data path while it is busy
    wire windowOpen = irqPath & (~cmdReq_ff.dataCmd | ~dataBusy); // RULE3
    wire irqClear   = wrLink & pwdata[sd_cmd_pkg::IRQSEEN_BIT];

    always_ff @(posedge clock) begin
        if (!resetn) begin
            wide4_ff   <= 1'b0;
            irqEn_ff   <= 1'b0;
            sdioIrq_ff <= 1'b0;
            irqSeen_ff <= 1'b0;
        end else if (ce) begin
            if (wrLink) begin
                wide4_ff <= pwdata[sd_cmd_pkg::WIDE4_BIT];
                irqEn_ff <= pwdata[sd_cmd_pkg::IRQEN_BIT];
            end
            // line 1 interrupt is signalled low by the card
            sdioIrq_ff <= windowOpen & ~card_data_line_1; // RULE3
            // a new interrupt wins over a clear in the same cycle
            irqSeen_ff <= sdioIrq_ff | (irqSeen_ff & ~irqClear);
        end
    end
    assign sdioIrq = sdioIrq_ff;

    // ---------------- read data ----------------
    // images are built field by field so the bit map lives only in the package
    logic [31:0] cmdRead;
    logic [31:0] ridxRead;
    logic [31:0] linkRead;
    always_comb begin
        cmdRead  = sd_cmd_pkg::REG_RESET;
        ridxRead = sd_cmd_pkg::REG_RESET;
        linkRead = sd_cmd_pkg::REG_RESET;
        cmdRead[sd_cmd_pkg::KIND_MSB:sd_cmd_pkg::KIND_LSB] = cmdKind_ff; // RULE1
        cmdRead[sd_cmd_pkg::DATA_BIT]                      = cmdData_ff;
        cmdRead[sd_cmd_pkg::INDEX_MSB:0]                   = cmdIndex_ff; // RULE6
        ridxRead[sd_cmd_pkg::INDEX_MSB:0]                  = replyIndex; // RULE7
        linkRead[sd_cmd_pkg::WIDE4_BIT]                    = wide4_ff;
        linkRead[sd_cmd_pkg::IRQEN_BIT]                    = irqEn_ff;
        linkRead[sd_cmd_pkg::BUSY_BIT]                     = busy;
        linkRead[sd_cmd_pkg::IRQSEEN_BIT]                  = irqSeen_ff;
    end
    wire [31:0] nxt_prdata =
        selArg  ? argument_ff :
        selCmd  ? cmdRead :
        selRidx ? ridxRead :
        selW0   ? replyWords[0*WW +: WW] :
        selW1   ? replyWords[1*WW +: WW] :
        selW2   ? replyWords[2*WW +: WW] :
        selW3   ? replyWords[3*WW +: WW] :
        selLink ? linkRead : sd_cmd_pkg::REG_RESET;

    // set once the read data is loaded, cleared when the access completes
    always_ff @(posedge clock) begin
        if (!resetn) begin
            rdLoaded_ff <= 1'b0;
        end else if (ce) begin
            rdLoaded_ff <= psel & ~pwrite & ~(penable & rdLoaded_ff);
        end
    end

    // loaded in the setup cycle, so a running block answers the access at once
    always_ff @(posedge clock) begin
        if (!resetn) begin
            prdata_ff <= sd_cmd_pkg::REG_RESET;
        end else if (loadRead) begin
            prdata_ff <= nxt_prdata;
        end
    end
    assign prdata = prdata_ff;

endmodule : sd_command_response
`default_nettype wire

// [sd_command_response_chk.sv]
// assertions on the command launch, reply capture and sdio interrupt ports
// sees only the top ports; bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module sd_command_response_chk #(
    parameter int ADDR_W = 8
) (
    input wire logic                 clock,
    input wire logic                 resetn,
    input wire logic                 ce,
    input wire logic [ADDR_W-1:0]    paddr,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [31:0]          pwdata,
    input wire sd_cmd_pkg::cmd_req_t cmdReq,
    input wire logic                 cmdValid,
    input wire logic                 cmdReady,
    input wire logic                 replyValid,
    input wire logic                 card_data_line_1,
    input wire logic                 sdioIrq,
    input wire logic                 busy
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    sequence s_launch;
        ce && psel && penable && pwrite && !busy && paddr == ADDR_W'(sd_cmd_pkg::OFF_COMMAND);
    endsequence
    sequence s_sent;
        ce && cmdValid && cmdReady;
    endsequence
    a_launch_valid: assert property (s_launch |=> cmdValid && busy) else $error("no launch");
    a_index_sent: assert property (s_launch |=> cmdReq.index == $past(pwdata[5:0])) else $error("index");
    a_kind_flag: assert property (s_launch |=> cmdReq.kind == $past(pwdata[10:8])
        && cmdReq.dataCmd == $past(pwdata[6])) else $error("kind or flag");
    a_valid_hold: assert property (cmdValid && !(ce && cmdReady) |=> cmdValid && $stable(cmdReq))
        else $error("request dropped");
    a_none_ends: assert property (s_sent ##0 cmdReq.kind == 3'h4 |=> !busy) else $error("no-reply hang");
    a_await_reply: assert property (s_sent ##0 cmdReq.kind != 3'h4 |=> busy && !cmdValid)
        else $error("no wait");
    a_reply_done: assert property (busy && !cmdValid && ce && replyValid |=> !busy) else $error("stuck");
    a_irq_line: assert property (sdioIrq && $past(ce) |-> !$past(card_data_line_1))
        else $error("irq without line");
endmodule : sd_command_response_chk
bind sd_command_response sd_command_response_chk #(.ADDR_W(ADDR_W)) i_chk (.clock, .resetn, .ce, .paddr,
    .psel, .penable, .pwrite, .pwdata, .cmdReq, .cmdValid, .cmdReady, .replyValid, .card_data_line_1,
    .sdioIrq, .busy);
`default_nettype wire

// [sd_command_response_tb.sv]
// self-checking bench for the card command/response block
// apb master tasks note expected reads in a queue; a monitor compares
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checksDone++; if ((g) !== (e)) begin errCount++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module sd_command_response_tb;
    logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, dataBusy = 0, dataLine1 = 1, ce = 1;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic pready, pslverr, cmdValid, cmdReady, replyValid, sdioIrq, busy;
    sd_cmd_pkg::cmd_req_t cmdReq;
    sd_cmd_pkg::reply_t replyIn;
    logic [3:0] lag = 4'h1;
    logic [5:0] rIdx = '0, expIdx = '0;
    logic [127:0] pay = '0, expPay = '0;
    logic [32:0] notes[$];
    logic [32:0] nt;
    int errCount = 0, checksDone = 0;
    initial forever #50 clock = ~clock;
    sd_command_response i_dut (.clock, .resetn, .ce, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .cmdReq, .cmdValid, .cmdReady, .replyIn, .replyValid, .dataBusy,
        .card_data_line_1(dataLine1), .sdioIrq, .busy);
    sd_card_model i_card (.clock, .cmdReq, .cmdValid, .cmdReady, .replyIn, .replyValid, .lag, .rIdx, .pay);
    always @(posedge clock) if (psel && penable && !pwrite && pready) begin
        nt = notes.pop_front();
        `CHK("prdata", nt[31:0], prdata)
        `CHK("pslverr", nt[32], pslverr)
    end
    task automatic printVerdict;
        $display("checks %0d errors %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : printVerdict
    // one idle edge after each transfer keeps setup and release apart
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        do @(posedge clock); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        @(posedge clock);
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er = 0);
        notes.push_back({er, e});
        apb(0, a, 32'h0);
    endtask : rd
    task automatic readReplies;
        rd(sd_cmd_pkg::OFF_REPLY_IDX, {26'h0, expIdx});
        rd(sd_cmd_pkg::OFF_REPLY_W0, expPay[39:8]);
        rd(sd_cmd_pkg::OFF_REPLY_W1, expPay[71:40]);
        rd(sd_cmd_pkg::OFF_REPLY_W2, expPay[103:72]);
        rd(sd_cmd_pkg::OFF_REPLY_W3, {8'h0, expPay[127:104]});
    endtask : readReplies
    task automatic launch(input logic [2:0] k, input logic f);
        logic [31:0] arg;
        logic [5:0] ix;
        arg = $urandom();
        ix = 6'($urandom());
        pay <= {$urandom(), $urandom(), $urandom(), $urandom()};
        rIdx <= 6'($urandom());
        lag <= 4'($urandom_range(0, 3));
        apb(1, sd_cmd_pkg::OFF_ARGUMENT, arg);
        apb(1, sd_cmd_pkg::OFF_COMMAND, {21'h0, k, 1'b0, f, ix});
        for (int n = 0; n < 20 && cmdValid !== 1'b1; n++) @(negedge clock);
        `CHK("argument", arg, cmdReq.argument)
        `CHK("kind", k, cmdReq.kind)
        `CHK("dataCmd", f, cmdReq.dataCmd)
        for (int n = 0; n < 40 && busy !== 1'b0; n++) @(negedge clock);
        `CHK("busy", 1'b0, busy)
        @(posedge clock);
        if (k != 3'h4) begin
            expIdx = (k == 3'h2 || k == 3'h3) ? 6'h3f : rIdx;
            expPay = pay;
        end
        readReplies();
        rd(sd_cmd_pkg::OFF_COMMAND, {21'h0, k, 1'b0, f, ix});
        rd(sd_cmd_pkg::OFF_ARGUMENT, arg);
    endtask : launch
    task automatic irq(input logic [31:0] ctl, input logic db, input logic e);
        // bit 9 clears the sticky flag so each call starts from a clean state
        apb(1, sd_cmd_pkg::OFF_LINK_CTRL, ctl | 32'h200);
        dataBusy <= db;
        dataLine1 <= 0;
        repeat (3) @(posedge clock);
        @(negedge clock);
        `CHK("sdioIrq", e, sdioIrq)
        @(posedge clock);
        dataLine1 <= 1;
        repeat (2) @(posedge clock);
        @(negedge clock);
        `CHK("sdioIrqIdle", 1'b0, sdioIrq)
        @(posedge clock);
        rd(sd_cmd_pkg::OFF_LINK_CTRL, {22'h0, e, 1'b0, 6'h0, ctl[1:0]});
    endtask : irq
    // a frozen block stalls the bus; the transfer ends once the clock enable returns
    task automatic frozen(input logic w, input logic [31:0] d);
        ce <= 0;
        fork
            if (w) apb(1, sd_cmd_pkg::OFF_ARGUMENT, d);
            else rd(sd_cmd_pkg::OFF_ARGUMENT, d);
            begin
                repeat (3) @(posedge clock);
                ce <= 1;
            end
        join
    endtask : frozen
    initial begin
        void'($urandom(53326));
        repeat (5) @(posedge clock);
        resetn <= 1;
        @(posedge clock);
        rd(sd_cmd_pkg::OFF_COMMAND, 32'h0);
        rd(sd_cmd_pkg::OFF_ARGUMENT, 32'h0);
        readReplies();
        for (int k = 0; k < 5; k++) launch(3'(k), 1'(k));
        // read-only words ignore writes, unmapped place errors
        apb(1, sd_cmd_pkg::OFF_REPLY_W0, 32'hffffffff);
        readReplies();
        rd(8'h3c, 32'h0, 1'b1);
        repeat (4) launch(3'($urandom_range(0, 4)), 1'($urandom()));
        launch(3'h4, 1'b0);
        irq(32'h3, 1'b1, 1'b1);
        irq(32'h2, 1'b0, 1'b0);
        irq(32'h1, 1'b0, 1'b0);
        launch(3'h4, 1'b1);
        irq(32'h3, 1'b1, 1'b0);
        irq(32'h3, 1'b0, 1'b1);
        frozen(1'b1, 32'h5a5a0f0f);
        frozen(1'b0, 32'h5a5a0f0f);
        printVerdict();
    end
    initial begin
        #(100 * 5000);
        errCount++;
        $display("watchdog expired");
        printVerdict();
    end
endmodule : sd_command_response_tb
`default_nettype wire
